// >>> inc/pgcd_cfg.svh
// Constants for the global configuration decoder
// Assumes inclusion by bare name from the design files
`ifndef PGCD_CFG_SVH
`define PGCD_CFG_SVH

// ----------------------------------------------------------------------
// Auxiliary output source codes
// ----------------------------------------------------------------------
`define PGCD_AUX_REF 2'h0
`define PGCD_AUX_FREQ 2'h1
`define PGCD_AUX_PLL 2'h2
`define PGCD_AUX_LOCK 2'h3

// ----------------------------------------------------------------------
// Third mode pin function codes
// ----------------------------------------------------------------------
`define PGCD_M2_DIS_MAIN 3'h0
`define PGCD_M2_DIS_AUX 3'h1
`define PGCD_M2_DIS_BOTH 3'h2
`define PGCD_M2_RSHIFT 3'h3
`define PGCD_M2_RSVD_A 3'h4
`define PGCD_M2_AUTOMOD 3'h5
`define PGCD_M2_RSVD_B 3'h6
`define PGCD_M2_FORCE_PLL 3'h7

// ----------------------------------------------------------------------
// Reference divider codes
// ----------------------------------------------------------------------
`define PGCD_DIV_4 2'h0
`define PGCD_DIV_2 2'h1
`define PGCD_DIV_1 2'h2
`define PGCD_DIV_RSVD 2'h3

// ----------------------------------------------------------------------
// Field widths, counts, bandwidth base and reset values
// ----------------------------------------------------------------------
`define PGCD_RATIO_W 32
`define PGCD_PART_W 20
`define PGCD_FRAC_LO_W 12
`define PGCD_FRAC_HI_W 20
`define PGCD_BW_BASE_HZ 8'h01
`define PGCD_SET_COUNT 4
`define PGCD_SET_RST 37'h0

`endif

// >>> inc/pgcd_pkg.sv
// Types shared by the global configuration decoder files
// Assumes pgcd_cfg.svh is on the include path
`include "pgcd_cfg.svh"

package pgcd_pkg;

  // --------------------------------------------------------------------
  // Global parameters, loaded once from one-time memory
  // --------------------------------------------------------------------
  typedef struct packed {
    logic auxLockPolaritySelect;
    logic [1:0] referenceDividerSelect;
    logic outputOnUnlockEnable;
    logic ratioFormatSelect;
    logic [2:0] thirdModePinFunction;
    logic [2:0] inputLoopBandwidthSelect;
  } pgcd_global_t;

  // --------------------------------------------------------------------
  // One modal configuration set
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] userRatio;
    logic [1:0] ratioShiftSelect;
    logic [1:0] auxOutputSourceSelect;
    logic automaticRatioModifierEnable;
  } pgcd_set_t;

  // --------------------------------------------------------------------
  // Decoded ratio in common integer and fraction form
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [19:0] intPart;
    logic [19:0] fracPart;
  } pgcd_ratio_t;

endpackage : pgcd_pkg

// >>> rtl/pgcd_set_mem.sv
// Four-entry store of modal configuration sets
// Assumes writes come from the one-time memory loader on ref_clk
`timescale 1ns/1ps
`include "pgcd_cfg.svh"

module pgcd_set_mem (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wrEn,
  input wire logic [1:0] wrIdx,
  input wire pgcd_pkg::pgcd_set_t wrData,
  input wire logic [1:0] rdIdx,
  output pgcd_pkg::pgcd_set_t rdData
);

  pgcd_pkg::pgcd_set_t mem [`PGCD_SET_COUNT];

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
  end

  // --------------------------------------------------------------------
  // Registered read
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdData <= `PGCD_SET_RST;
    end else begin
      rdData <= mem[rdIdx];
    end
  end

endmodule : pgcd_set_mem

// >>> rtl/pgcd_top.sv
// Global configuration decoder and clock routing for the multiplier
// Assumes clocks and pins are sampled on ref_clk through two flip-flops
`timescale 1ns/1ps
`include "pgcd_cfg.svh"

module pgcd_top (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire pgcd_pkg::pgcd_global_t globalCfgIn,
  input wire logic setWrEn,
  input wire logic [1:0] setWrIdx,
  input wire pgcd_pkg::pgcd_set_t setWrData,
  input wire logic [2:0] modePins,
  input wire logic pllLocked,
  input wire logic refClkIn,
  input wire logic freqRefIn,
  input wire logic pllClkIn,
  output logic cfgValid,
  output logic configReserved,
  output logic clkOutMain,
  output logic auxOutData,
  output logic auxOutEn,
  output logic refDivClk,
  output logic ratioShiftEnable,
  output logic [1:0] ratioShiftSelect,
  output logic autoRatioModEnable,
  output logic [31:0] activeRatio,
  output pgcd_pkg::pgcd_ratio_t ratioSplit,
  output logic [7:0] loopBandwidthHz
);

  pgcd_pkg::pgcd_global_t cfg;
  pgcd_pkg::pgcd_set_t setRd;
  logic [2:0] modeMeta, modeSync;
  logic lockMeta, lockSync;
  logic [2:0] clkMeta, clkSync;
  logic refPrev, divCnt;
  logic mainDis, auxDis, unlockGate, m2;
  logic [2:0] fn;
  logic [1:0] auxSrc;
  logic next_clkOutMain, next_auxOutData, next_auxOutEn;

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  function automatic pgcd_pkg::pgcd_ratio_t splitRatio(
    input logic [31:0] r, input logic fmt);
    pgcd_pkg::pgcd_ratio_t s;
    if (fmt) begin
      s.intPart = {8'h00, r[31:20]};
      s.fracPart = r[19:0];
    end else begin
      s.intPart = r[31:12];
      s.fracPart = {r[11:0], 8'h00};
    end
    return s;
  endfunction : splitRatio

  function automatic logic [7:0] bwHz(input logic [2:0] sel);
    return `PGCD_BW_BASE_HZ << sel;
  endfunction : bwHz

  // --------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      modeMeta <= 3'h0;
      modeSync <= 3'h0;
      lockMeta <= 1'h0;
      lockSync <= 1'h0;
      clkMeta <= 3'h0;
      clkSync <= 3'h0;
    end else begin
      modeMeta <= modePins;
      modeSync <= modeMeta;
      lockMeta <= pllLocked;
      lockSync <= lockMeta;
      clkMeta <= {pllClkIn, freqRefIn, refClkIn};
      clkSync <= clkMeta;
    end
  end

  // --------------------------------------------------------------------
  // Global capture after reset release
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg <= '0;
      cfgValid <= 1'h0;
    end else if (!cfgValid) begin
      cfg <= globalCfgIn;
      cfgValid <= 1'h1;
    end
  end

  // --------------------------------------------------------------------
  // Modal set store
  // --------------------------------------------------------------------
  pgcd_set_mem u_sets (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .wrEn(setWrEn),
    .wrIdx(setWrIdx),
    .wrData(setWrData),
    .rdIdx(modeSync[1:0]),
    .rdData(setRd)
  );

  // --------------------------------------------------------------------
  // Routing decode
  // --------------------------------------------------------------------
  always_comb begin
    m2 = modeSync[2];
    fn = cfg.thirdModePinFunction;
    mainDis = m2 && (fn == `PGCD_M2_DIS_MAIN ||
                     fn == `PGCD_M2_DIS_BOTH);
    auxDis = m2 && (fn == `PGCD_M2_DIS_AUX ||
                    fn == `PGCD_M2_DIS_BOTH);
    auxSrc = setRd.auxOutputSourceSelect;
    if (m2 && fn == `PGCD_M2_FORCE_PLL) begin
      auxSrc = `PGCD_AUX_PLL;
    end
    unlockGate = !cfg.outputOnUnlockEnable && !lockSync;
    next_clkOutMain = cfgValid && clkSync[2] && !mainDis && !unlockGate;
    next_auxOutEn = cfgValid;
    next_auxOutData = 1'h0;
    case (auxSrc)
      `PGCD_AUX_REF: next_auxOutData = clkSync[0] && !auxDis;
      `PGCD_AUX_FREQ: next_auxOutData = clkSync[1] && !auxDis;
      `PGCD_AUX_PLL: next_auxOutData = clkSync[2] && !auxDis && !unlockGate;
      `PGCD_AUX_LOCK: begin
        if (cfg.auxLockPolaritySelect) begin
          next_auxOutEn = cfgValid && !lockSync && !auxDis;
        end else begin
          next_auxOutData = !lockSync && !auxDis;
        end
      end
      default: next_auxOutData = 1'h0;
    endcase
  end

  // --------------------------------------------------------------------
  // Clock and lock outputs
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clkOutMain <= 1'h0;
      auxOutData <= 1'h0;
      auxOutEn <= 1'h0;
    end else begin
      clkOutMain <= next_clkOutMain;
      auxOutData <= next_auxOutData;
      auxOutEn <= next_auxOutEn;
    end
  end

  // --------------------------------------------------------------------
  // Reference divider
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      refPrev <= 1'h0;
      divCnt <= 1'h0;
      refDivClk <= 1'h0;
    end else begin
      refPrev <= clkSync[0];
      case (cfg.referenceDividerSelect)
        `PGCD_DIV_4: begin
          if (clkSync[0] && !refPrev) begin
            divCnt <= !divCnt;
            if (divCnt) begin
              refDivClk <= !refDivClk;
            end
          end
        end
        `PGCD_DIV_2: begin
          if (clkSync[0] && !refPrev) begin
            refDivClk <= !refDivClk;
          end
        end
        `PGCD_DIV_1: refDivClk <= clkSync[0];
        default: refDivClk <= 1'h0;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Ratio and loop controls
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ratioShiftEnable <= 1'h0;
      ratioShiftSelect <= 2'h0;
      autoRatioModEnable <= 1'h0;
      activeRatio <= 32'h0;
      ratioSplit <= '0;
      loopBandwidthHz <= 8'h0;
      configReserved <= 1'h0;
    end else begin
      ratioShiftEnable <= fn == `PGCD_M2_RSHIFT && m2;
      ratioShiftSelect <= setRd.ratioShiftSelect;
      autoRatioModEnable <= (fn == `PGCD_M2_AUTOMOD) ? m2 :
        setRd.automaticRatioModifierEnable;
      activeRatio <= setRd.userRatio;
      ratioSplit <= splitRatio(setRd.userRatio,
        cfg.ratioFormatSelect);
      loopBandwidthHz <= bwHz(cfg.inputLoopBandwidthSelect);
      configReserved <= fn == `PGCD_M2_RSVD_A || fn == `PGCD_M2_RSVD_B ||
        cfg.referenceDividerSelect == `PGCD_DIV_RSVD;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  sequence s_lockSrc;
    cfgValid && auxSrc == `PGCD_AUX_LOCK && !auxDis;
  endsequence

  sequence s_unlocked;
    cfgValid && !cfg.outputOnUnlockEnable && !lockSync;
  endsequence

  property p_push_pull;
    @(posedge ref_clk) disable iff (!nrst)
      s_lockSrc ##0 !cfg.auxLockPolaritySelect |=>
        auxOutEn && auxOutData == !$past(lockSync);
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("push-pull unlock level wrong");

  property p_open_drain;
    @(posedge ref_clk) disable iff (!nrst)
      s_lockSrc ##0 cfg.auxLockPolaritySelect |=>
        !auxOutData && auxOutEn == !$past(lockSync);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain unlock drive wrong");

  property p_aux_clock;
    @(posedge ref_clk) disable iff (!nrst)
      cfgValid && auxSrc != `PGCD_AUX_LOCK |=> auxOutEn;
  endproperty
  a_aux_clock: assert property (p_aux_clock)
    else $error("aux clock source not driven");

  property p_unlock_gate;
    @(posedge ref_clk) disable iff (!nrst)
      s_unlocked |=> !clkOutMain;
  endproperty
  a_unlock_gate: assert property (p_unlock_gate)
    else $error("main clock not held low while unlocked");

  property p_unlock_keep;
    @(posedge ref_clk) disable iff (!nrst)
      cfgValid && cfg.outputOnUnlockEnable && !mainDis |=>
        clkOutMain == $past(clkSync[2]);
  endproperty
  a_unlock_keep: assert property (p_unlock_keep)
    else $error("main clock gated despite enable");

  property p_format;
    @(posedge ref_clk) disable iff (!nrst)
      cfgValid |=> ratioSplit.fracPart[7:0] == 8'h00 ||
        $past(cfg.ratioFormatSelect);
  endproperty
  a_format: assert property (p_format)
    else $error("20.12 fraction not left aligned");

  property p_disable;
    @(posedge ref_clk) disable iff (!nrst)
      mainDis |=> !clkOutMain;
  endproperty
  a_disable: assert property (p_disable)
    else $error("main clock not disabled by pin");

  property p_rshift;
    @(posedge ref_clk) disable iff (!nrst)
      fn != `PGCD_M2_RSHIFT || !m2 |=> !ratioShiftEnable;
  endproperty
  a_rshift: assert property (p_rshift)
    else $error("ratio shift enabled without pin");

  property p_force;
    @(posedge ref_clk) disable iff (!nrst)
      cfgValid && m2 && fn == `PGCD_M2_FORCE_PLL && !unlockGate |=>
        auxOutEn && auxOutData == $past(clkSync[2]);
  endproperty
  a_force: assert property (p_force)
    else $error("aux not forced to PLL clock");

  property p_bw;
    @(posedge ref_clk) disable iff (!nrst)
      cfgValid |=> loopBandwidthHz ==
        8'h01 << $past(cfg.inputLoopBandwidthSelect);
  endproperty
  a_bw: assert property (p_bw)
    else $error("loop bandwidth code wrong");

  property p_static;
    @(posedge ref_clk) disable iff (!nrst)
      cfgValid |=> $stable(cfg);
  endproperty
  a_static: assert property (p_static)
    else $error("global parameters changed");

endmodule : pgcd_top

// >>> dv/pgcd_clk_sink.sv
// Model of the system logic that consumes the multiplied clocks
// Assumes clkIn is slow next to ref_clk; the aux line has a pull-up
`timescale 1ns/1ps

module pgcd_clk_sink (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkIn,
  input wire logic auxOutData,
  input wire logic auxOutEn,
  input wire logic clr,
  output logic [7:0] riseCnt,
  output wire logic auxPin
);
  logic clkQ;

  // Released aux line is pulled high
  assign auxPin = auxOutEn ? auxOutData : 1'b1;

  // ---------------------------------------------------------------
  // Rising edge counter of the consumed clock
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clkQ <= 1'b0;
      riseCnt <= 8'h00;
    end else begin
      clkQ <= clkIn;
      if (clr) begin
        riseCnt <= 8'h00;
      end else if (clkIn && !clkQ) begin
        riseCnt <= riseCnt + 8'h01;
      end
    end
  end
endmodule : pgcd_clk_sink

// >>> dv/tb_top.sv
// Self-checking bench for the global configuration decoder
// Assumes pgcd_pkg is compiled first and pgcd_cfg.svh is on the path
`timescale 1ns/1ps

module tb_top;
  logic ref_clk = 1'b0;
  logic nrst, setWrEn, pllLocked;
  logic refClkIn = 1'b0, freqRefIn = 1'b0, pllClkIn = 1'b1;
  logic pllRun, clr, refDivQ = 1'b0;
  pgcd_pkg::pgcd_global_t globalCfgIn;
  logic [1:0] setWrIdx;
  pgcd_pkg::pgcd_set_t setWrData;
  logic [2:0] modePins;
  logic cfgValid, configReserved, clkOutMain, auxOutData, auxOutEn;
  logic refDivClk, ratioShiftEnable, autoRatioModEnable;
  logic [1:0] ratioShiftSelect;
  logic [31:0] activeRatio;
  pgcd_pkg::pgcd_ratio_t ratioSplit;
  logic [7:0] loopBandwidthHz, mainCnt;
  logic [7:0] divCnt = 8'h00;
  wire auxPin;
  int num_errors = 0;
  int n_checks = 0;
  // First two are quotients times 2^20, last two 20.12 values
  logic [31:0] ratioTab [4] = '{32'h0013A92A, 32'h10000000,
    32'h32000000, 32'h2DF5E208};
  logic [1:0] srcTab [4] = '{2'h3, 2'h2, 2'h0, 2'h1};

  always #2 ref_clk = ~ref_clk;

  // ---------------------------------------------------------------
  // Clock stimulus and divided reference edge counter
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    refClkIn <= ~refClkIn;
    freqRefIn <= refClkIn;
    pllClkIn <= pllRun ? ~pllClkIn : 1'b1;
    refDivQ <= refDivClk;
    if (clr) begin
      divCnt <= 8'h00;
    end else if (refDivClk && !refDivQ) begin
      divCnt <= divCnt + 8'h01;
    end
  end

  pgcd_top dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .globalCfgIn(globalCfgIn),
    .setWrEn(setWrEn), .setWrIdx(setWrIdx), .setWrData(setWrData),
    .modePins(modePins), .pllLocked(pllLocked), .refClkIn(refClkIn),
    .freqRefIn(freqRefIn), .pllClkIn(pllClkIn), .cfgValid(cfgValid),
    .configReserved(configReserved), .clkOutMain(clkOutMain),
    .auxOutData(auxOutData), .auxOutEn(auxOutEn), .refDivClk(refDivClk),
    .ratioShiftEnable(ratioShiftEnable),
    .ratioShiftSelect(ratioShiftSelect),
    .autoRatioModEnable(autoRatioModEnable), .activeRatio(activeRatio),
    .ratioSplit(ratioSplit), .loopBandwidthHz(loopBandwidthHz)
  );

  pgcd_clk_sink sink_u (
    .ref_clk(ref_clk), .nrst(nrst), .clkIn(clkOutMain),
    .auxOutData(auxOutData), .auxOutEn(auxOutEn), .clr(clr),
    .riseCnt(mainCnt), .auxPin(auxPin)
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  task st(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : st

  task pins(input logic [2:0] p, input logic lk);
    modePins <= p;
    pllLocked <= lk;
    st(6);
  endtask : pins

  function automatic logic [39:0] splitOf(input logic [31:0] r,
    input logic f);
    if (f) begin
      return {8'h00, r[31:20], r[19:0]};
    end
    return {r[31:12], r[11:0], 8'h00};
  endfunction : splitOf

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  initial begin
    #100000;
    num_errors++;
    results();
  end

  // ---------------------------------------------------------------
  // Main sequence: one reset per global setting
  // ---------------------------------------------------------------
  initial begin
    int i, k, e;
    logic [2:0] fn;
    logic [1:0] dv;
    logic pol, unl, fmt;
    pgcd_pkg::pgcd_global_t g;
    nrst <= 1'b0;
    globalCfgIn <= '0;
    setWrEn <= 1'b0;
    setWrIdx <= 2'h0;
    setWrData <= '0;
    modePins <= 3'h0;
    pllLocked <= 1'b0;
    pllRun <= 1'b0;
    clr <= 1'b0;
    st(2);
    for (i = 0; i < 8; i++) begin
      fn = i[2:0];
      dv = i[1:0];
      pol = i[0];
      unl = i[1];
      fmt = i[2];
      g = {pol, dv, unl, fmt, fn, i[2:0]};
      nrst <= 1'b0;
      globalCfgIn <= g;
      modePins <= 3'h0;
      pllLocked <= 1'b1;
      st(2);
      nrst <= 1'b1;
      st(2);
      globalCfgIn <= ~g;
      setWrEn <= 1'b1;
      for (k = 0; k < 4; k++) begin
        setWrIdx <= k[1:0];
        setWrData <= {ratioTab[k], k[1:0], srcTab[k], 1'b0};
        st(1);
      end
      setWrEn <= 1'b0;
      st(6);
      chk(cfgValid, 1'b1);
      chk(loopBandwidthHz, 8'h01 << i);
      chk(configReserved, fn == 3'h4 || fn == 3'h6 || dv == 2'h3);
      for (k = 0; k < 4; k++) begin
        pins({1'b0, k[1:0]}, 1'b1);
        chk(activeRatio, ratioTab[k]);
        chk(ratioSplit, splitOf(ratioTab[k], fmt));
        if (k > 1) begin
          chk({auxOutEn, auxOutData}, {1'b1, refClkIn ^ (k == 2)});
        end
      end
      // Set 0 shows the unlock indicator
      for (k = 0; k < 2; k++) begin
        pins(3'h0, k[0]);
        chk(auxOutEn, pol ? !k[0] : 1'b1);
        chk(auxPin, pol ? k[0] : !k[0]);
      end
      // Set 1 carries the PLL clock, held high
      pins(3'h1, 1'b0);
      chk(clkOutMain, unl);
      chk(auxOutData, unl);
      pins(3'h1, 1'b1);
      chk({auxOutEn, auxOutData}, 2'h3);
      chk({ratioShiftEnable, autoRatioModEnable}, 2'h0);
      pins(3'h5, 1'b1);
      chk(clkOutMain, !(fn == 3'h0 || fn == 3'h2));
      chk(auxOutData, !(fn == 3'h1 || fn == 3'h2));
      chk(ratioShiftEnable, fn == 3'h3);
      chk(ratioShiftSelect, 2'h1);
      chk(autoRatioModEnable, fn == 3'h5);
      pins(3'h4, 1'b1);
      chk(auxPin, fn == 3'h7 || pol);
      chk({auxOutEn, auxOutData}, {fn == 3'h7 || !pol, fn == 3'h7});
      // Divided reference and running clock output
      pllRun <= 1'b1;
      pins(3'h1, 1'b1);
      clr <= 1'b1;
      st(1);
      clr <= 1'b0;
      st(64);
      e = (dv == 2'h3) ? 0 : (32 >> (2 - dv));
      chk(int'(divCnt) + 1 >= e && int'(divCnt) <= e + 1, 1'b1);
      chk(mainCnt >= 8'h1F && mainCnt <= 8'h21, 1'b1);
      pllRun <= 1'b0;
      st(2);
    end
    results();
  end
endmodule : tb_top
